//--- rtl/clock_control.sv
// System clock control: source selection, external clock monitor,
// bus, timer and ADC clock-enable ticks, and its register port.
// Assumes oscillator pins are asynchronous and sampled at 100 MHz.
// Operation
// - Internal RC is the source after reset
// - External clock selectable and monitored while used
// - External failure falls back to internal RC
// - External failure interrupt only when enabled
// - PLL input failure from external also reported
// - Advanced timer clock never above 144MHz
// - ADC clock from bus divided 1,2,4
// - ADC clock from PLL divided 1 to 256
// - Timer x2 only from PLL, division at most 2
// - Stop state halts clocks and oscillators
//
// Local design decisions: strobed register access and the register addresses.
`include "clock_control_cfg.svh"

module clock_control
    import clock_control_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic rc_osc_in,
    input wire logic ext_clock_in,
    input wire logic pll_clock_in,
    input wire logic stop_mode,
    input reg_req_type reg_req,
    output logic [31:0] reg_rdata,
    output clock_ticks_type ticks,
    output osc_enable_type osc_enable,
    output src_type active_source,
    output logic irq
);
    localparam logic [7:0] TIMEOUT = 8'(`CC_EXT_TIMEOUT_CYC);

    // Pin synchronisers: index 0 RC, 1 external, 2 PLL
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    logic [2:0] rise;
    logic ext_any_edge;
    logic pll_both_edge;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            pin_prev <= 3'h0;
        end
        else if (clk_en)
        begin
            pin_meta <= {pll_clock_in, ext_clock_in, rc_osc_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign rise = pin_sync & ~pin_prev;
    assign ext_any_edge = pin_sync[1] ^ pin_prev[1];
    assign pll_both_edge = pin_sync[2] ^ pin_prev[2];

    // Software registers
    logic [6:0] ctrl;
    logic [19:0] presc;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [6:0] next_ctrl;
    logic [19:0] next_presc;
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    logic [31:0] next_reg_rdata;
    logic [1:0] irq_events;
    logic clr_fail;

    src_type src_req;
    logic pll_from_ext;
    logic ext_en;
    logic pll_en;
    logic [3:0] ahb_code;
    logic [2:0] apb1_code;
    logic [2:0] apb2_code;
    logic [1:0] adc_bus_code;
    logic [7:0] adc_pll_m1;

    assign src_req = (ctrl[1:0] == 2'h2) ? SRC_PLL :
                     (ctrl[1:0] == 2'h1) ? SRC_EXT : SRC_RC;
    assign pll_from_ext = ctrl[`CC_CTRL_PLL_FROM_EXT];
    assign ext_en = ctrl[`CC_CTRL_EXT_EN];
    assign pll_en = ctrl[`CC_CTRL_PLL_EN];
    assign ahb_code = (presc[3:0] > `CC_AHB_CODE_MAX) ?
                      `CC_AHB_CODE_MAX : presc[3:0];
    assign apb1_code = (presc[6:4] > `CC_APB_CODE_MAX) ?
                       `CC_APB_CODE_MAX : presc[6:4];
    assign apb2_code = (presc[9:7] > `CC_APB_CODE_MAX) ?
                       `CC_APB_CODE_MAX : presc[9:7];
    assign adc_bus_code = (presc[11:10] == 2'h3) ? 2'h2 : presc[11:10];
    assign adc_pll_m1 = presc[19:12];
    assign clr_fail = reg_req.wr && reg_req.addr == `CC_CTRL_OFFSET &&
                      reg_req.wdata[`CC_CTRL_CLR_FAIL];

    // Source switching and external monitor state
    switch_state_type state;
    switch_state_type next_state;
    src_type active;
    src_type target;
    src_type next_active;
    src_type next_target;
    src_type eff_req;
    logic [7:0] mon_cnt;
    logic [7:0] next_mon_cnt;
    logic ext_failed;
    logic next_ext_failed;
    logic ext_in_use;
    logic fail_event;
    logic force_rc;
    logic [2:0] src_edge;
    logic tim_x2_ok;

    always_comb
    begin
        next_ctrl = ctrl;
        next_presc = presc;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_reg_rdata = 32'h0000_0000;
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                `CC_CTRL_OFFSET: next_ctrl = reg_req.wdata[6:0];
                `CC_PRESC_OFFSET: next_presc = reg_req.wdata[19:0];
                `CC_IRQ_MASK_OFFSET: next_irq_mask = reg_req.wdata[1:0];
                default: ;
            endcase
        end
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                `CC_CTRL_OFFSET: next_reg_rdata = {25'h0, ctrl};
                `CC_PRESC_OFFSET: next_reg_rdata = {12'h0, presc};
                `CC_STATUS_OFFSET:
                    next_reg_rdata = {27'h0, stop_mode, tim_x2_ok,
                                      ext_failed, active};
                `CC_IRQ_STATUS_OFFSET:
                begin
                    next_reg_rdata = {30'h0, irq_status};
                    next_irq_status = 2'h0;
                end
                `CC_IRQ_MASK_OFFSET: next_reg_rdata = {30'h0, irq_mask};
                default: next_reg_rdata = 32'h0000_0000;
            endcase
        end
        // A failure in the reading cycle survives the clear
        next_irq_status = next_irq_status | irq_events;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= `CC_CTRL_RESET;
            presc <= `CC_PRESC_RESET;
            irq_status <= `CC_IRQ_RESET;
            irq_mask <= `CC_IRQ_RESET;
            reg_rdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            ctrl <= next_ctrl;
            presc <= next_presc;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            reg_rdata <= next_reg_rdata;
        end
    end

    assign irq = |(irq_status & irq_mask);

    assign ext_in_use = ext_en && !stop_mode && (src_req == SRC_EXT ||
                        active == SRC_EXT || (pll_en && pll_from_ext));
    assign fail_event = ext_in_use && !ext_failed && mon_cnt == TIMEOUT;
    assign irq_events[`CC_IRQ_EXT_FAIL] = fail_event &&
        (src_req == SRC_EXT || active == SRC_EXT);
    assign irq_events[`CC_IRQ_PLL_FAIL] = fail_event &&
        pll_en && pll_from_ext;
    assign force_rc = ext_failed && (active == SRC_EXT ||
                      (active == SRC_PLL && pll_from_ext));
    assign src_edge = {rise[2] && pll_en, rise[1] && ext_en, rise[0]};

    always_comb
    begin
        next_state = state;
        next_active = active;
        next_target = target;
        next_mon_cnt = mon_cnt;
        next_ext_failed = (ext_failed && !clr_fail) || fail_event;
        eff_req = src_req;
        // A dead external clock is never selected again until cleared
        if (ext_failed && (src_req == SRC_EXT ||
            (src_req == SRC_PLL && pll_from_ext)))
        begin
            eff_req = SRC_RC;
        end
        // A cleared failure restarts the watch, else a stale count refails
        if (!ext_in_use || ext_any_edge || clr_fail)
        begin
            next_mon_cnt = 8'h00;
        end
        else if (mon_cnt != TIMEOUT)
        begin
            next_mon_cnt = mon_cnt + 8'h01;
        end
        unique case (state)
            ST_RUN:
            begin
                if (force_rc)
                begin
                    next_active = SRC_RC;
                end
                else if (eff_req != active)
                begin
                    next_target = eff_req;
                    next_state = ST_SWITCH;
                end
            end
            ST_SWITCH:
            begin
                if (force_rc || eff_req == active)
                begin
                    next_active = force_rc ? SRC_RC : active;
                    next_state = ST_RUN;
                end
                else if (eff_req != target)
                begin
                    next_target = eff_req;
                end
                else if (src_edge[target])
                begin
                    // Hand over on an edge of the new source: no runt
                    next_active = target;
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_RUN;
            active <= SRC_RC;
            target <= SRC_RC;
            mon_cnt <= 8'h00;
            ext_failed <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            active <= next_active;
            target <= next_target;
            mon_cnt <= next_mon_cnt;
            ext_failed <= next_ext_failed;
        end
    end

    assign active_source = active;

    // Tick generation
    logic core_tick;
    logic pll_tick;
    logic ahb_tick;
    logic apb1_tick;
    logic apb2_tick;
    logic advanced_control_timer_tick;
    logic tim2_tick;
    logic adc_bus_tick;
    logic adc_pll_tick;
    logic [8:0] ahb_m1;
    logic [3:0] apb1_m1;
    logic [3:0] apb2_m1;
    logic [3:0] advanced_control_timer_m1;
    logic [3:0] tim2_m1;
    logic [1:0] adc_bus_m1;
    clock_ticks_type next_ticks;

    assign ahb_m1 = 9'((10'h001 << ahb_code) - 10'h001);
    assign apb1_m1 = 4'((5'h01 << apb1_code) - 5'h01);
    assign apb2_m1 = 4'((5'h01 << apb2_code) - 5'h01);
    // Timer period is half the bus period unless the bus is undivided
    assign advanced_control_timer_m1 = (apb1_code == 3'h0) ? 4'h0 : apb1_m1 >> 1;
    assign tim2_m1 = (apb2_code == 3'h0) ? 4'h0 : apb2_m1 >> 1;
    assign adc_bus_m1 = 2'((3'h1 << adc_bus_code) - 3'h1);
    assign tim_x2_ok = active == SRC_PLL && pll_en &&
                       ({1'b0, ahb_code} + {1'b0, apb2_code}) <= 5'h01;
    assign pll_tick = rise[2] && pll_en && !stop_mode;

    always_comb
    begin
        core_tick = src_edge[active] && !stop_mode;
        next_ticks.core = core_tick;
        next_ticks.ahb = ahb_tick;
        next_ticks.apb1 = apb1_tick;
        next_ticks.apb2 = apb2_tick;
        next_ticks.tim_apb1 = advanced_control_timer_tick;
        next_ticks.tim_apb2 = tim2_tick;
        // Both PLL edges give twice its rate, allowed only as limited
        if (ctrl[`CC_CTRL_TIM_X2] && tim_x2_ok)
        begin
            next_ticks.adv_timer = pll_both_edge && !stop_mode;
        end
        else
        begin
            next_ticks.adv_timer = tim2_tick;
        end
        next_ticks.adc = ctrl[`CC_CTRL_ADC_FROM_PLL] ?
                         adc_pll_tick : adc_bus_tick;
        // Divider outputs lag the core tick, so gate them all here
        if (stop_mode)
        begin
            next_ticks = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ticks <= '0;
        end
        else if (clk_en)
        begin
            ticks <= next_ticks;
        end
    end

    clock_divider #(.WIDTH(9)) ahb_div (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .tick_in(core_tick), .ratio_m1(ahb_m1), .tick_out(ahb_tick));
    clock_divider #(.WIDTH(4)) apb1_div (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .tick_in(ahb_tick), .ratio_m1(apb1_m1), .tick_out(apb1_tick));
    clock_divider #(.WIDTH(4)) apb2_div (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .tick_in(ahb_tick), .ratio_m1(apb2_m1), .tick_out(apb2_tick));
    clock_divider #(.WIDTH(4)) advanced_control_timer_div (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .tick_in(ahb_tick), .ratio_m1(advanced_control_timer_m1), .tick_out(advanced_control_timer_tick));
    clock_divider #(.WIDTH(4)) tim2_div (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .tick_in(ahb_tick), .ratio_m1(tim2_m1), .tick_out(tim2_tick));
    clock_divider #(.WIDTH(2)) adc_bus_div (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .tick_in(ahb_tick), .ratio_m1(adc_bus_m1),
        .tick_out(adc_bus_tick));
    clock_divider #(.WIDTH(8)) adc_pll_div (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .tick_in(pll_tick), .ratio_m1(adc_pll_m1),
        .tick_out(adc_pll_tick));

    // Stop state drops every oscillator request
    assign osc_enable.rc_enable = !stop_mode;
    assign osc_enable.ext_enable = ext_en && !stop_mode;
    assign osc_enable.pll_enable = pll_en && !stop_mode;

endmodule : clock_control

//--- rtl/clock_divider.sv
// Tick divider: passes one of every (ratio_m1 + 1) input ticks.
// Assumes single-cycle input ticks in the sys_clk domain.
module clock_divider
    import clock_control_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic tick_in,
    input wire logic [WIDTH-1:0] ratio_m1,
    output logic tick_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] ratio_cur;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] next_ratio_cur;
    logic next_tick_out;

    // A new ratio is taken only at a wrap so no shortened period appears
    always_comb
    begin
        next_count = count;
        next_ratio_cur = ratio_cur;
        next_tick_out = 1'b0;
        if (tick_in)
        begin
            if (count >= ratio_cur)
            begin
                next_count = '0;
                next_tick_out = 1'b1;
                next_ratio_cur = ratio_m1;
            end
            else
            begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= '0;
            ratio_cur <= '0;
            tick_out <= 1'b0;
        end
        else if (clk_en)
        begin
            count <= next_count;
            ratio_cur <= next_ratio_cur;
            tick_out <= next_tick_out;
        end
    end

endmodule : clock_divider

//--- shared/clock_control_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock
// control block. Assumes the includer sits in the 100 MHz sys_clk domain.
`ifndef CLOCK_CONTROL_CFG_SVH
`define CLOCK_CONTROL_CFG_SVH

`define CC_ADDR_W 8
`define CC_CTRL_OFFSET 8'h00
`define CC_PRESC_OFFSET 8'h04
`define CC_STATUS_OFFSET 8'h08
`define CC_IRQ_STATUS_OFFSET 8'h0C
`define CC_IRQ_MASK_OFFSET 8'h10

`define CC_CTRL_SRC_LSB 0
`define CC_CTRL_PLL_FROM_EXT 2
`define CC_CTRL_EXT_EN 3
`define CC_CTRL_PLL_EN 4
`define CC_CTRL_ADC_FROM_PLL 5
`define CC_CTRL_TIM_X2 6
`define CC_CTRL_CLR_FAIL 7
`define CC_CTRL_RESET 7'h00

`define CC_PRESC_AHB_LSB 0
`define CC_PRESC_APB1_LSB 4
`define CC_PRESC_APB2_LSB 7
`define CC_PRESC_ADC_BUS_LSB 10
`define CC_PRESC_ADC_PLL_LSB 12
`define CC_PRESC_RESET 20'h0_0000

`define CC_AHB_CODE_MAX 4'h9
`define CC_APB_CODE_MAX 3'h4
`define CC_IRQ_EXT_FAIL 0
`define CC_IRQ_PLL_FAIL 1
`define CC_IRQ_RESET 2'h0

`define CC_SYS_CLK_MHZ 100
`define CC_EXT_TIMEOUT_NS 1000
`define CC_EXT_TIMEOUT_CYC ((`CC_EXT_TIMEOUT_NS * `CC_SYS_CLK_MHZ) / 1000)

`endif

//--- shared/clock_control_pkg.sv
// Types shared by the clock control block and its bench.
// Assumes clock_control_cfg.svh for the numeric layout.
package clock_control_pkg;

    typedef enum logic [1:0] {SRC_RC, SRC_EXT, SRC_PLL} src_type;

    typedef enum logic {ST_RUN, ST_SWITCH} switch_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic core;
        logic ahb;
        logic apb1;
        logic apb2;
        logic tim_apb1;
        logic tim_apb2;
        logic adv_timer;
        logic adc;
    } clock_ticks_type;

    typedef struct packed {
        logic rc_enable;
        logic ext_enable;
        logic pll_enable;
    } osc_enable_type;

endpackage : clock_control_pkg

//--- test/clock_control_chk.sv
// Port checker for the clock control block.
// Assumes one sys_clk domain and an active-low asynchronous reset.
module clock_control_chk
    import clock_control_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic stop_mode,
    input reg_req_type reg_req,
    input wire logic [31:0] reg_rdata,
    input clock_ticks_type ticks,
    input osc_enable_type osc_enable,
    input src_type active_source,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_reset_rc_source: assert property (
        !$past(resetn) |-> active_source == SRC_RC && !irq)
        else $error("source or irq wrong after reset");
    a_ext_osc_on: assert property (
        active_source == SRC_EXT && !stop_mode |-> osc_enable.ext_enable)
        else $error("external source used while disabled");
    a_pll_osc_on: assert property (
        active_source == SRC_PLL && !stop_mode |-> osc_enable.pll_enable)
        else $error("pll source used while disabled");
    a_fail_fallback: assert property (
        $rose(irq) && active_source == SRC_EXT
        |-> ##[1:2] active_source == SRC_RC)
        else $error("no fallback to rc after failure");
    a_stop_osc_off: assert property (
        stop_mode |-> osc_enable == 3'b000)
        else $error("oscillator enabled in stop state");
    a_stop_ticks_off: assert property (
        $past(stop_mode) |-> ticks == 8'h00)
        else $error("tick seen in stop state");
    a_core_no_runt: assert property (
        ticks.core |=> !ticks.core)
        else $error("runt core tick");
    a_ahb_no_runt: assert property (
        ticks.ahb |=> !ticks.ahb)
        else $error("runt bus tick");
    a_rdata_idle: assert property (
        !$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read answer cycle");
endmodule : clock_control_chk

bind clock_control clock_control_chk clock_control_chk_i (
    .sys_clk(sys_clk), .resetn(resetn), .stop_mode(stop_mode),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .ticks(ticks),
    .osc_enable(osc_enable), .active_source(active_source), .irq(irq));

//--- test/osc_model.sv
// Oscillator pins seen by the clock control block: RC, external, PLL.
// Assumes the block's enables gate each source; a disabled one sits low.
module osc_model
    import clock_control_pkg::*;
(
    input osc_enable_type osc_enable,
    input wire logic ext_run,
    input wire logic pll_run,
    output logic rc_osc_in,
    output logic ext_clock_in,
    output logic pll_clock_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        rc_osc_in = 1'b0;
        ext_clock_in = 1'b0;
        pll_clock_in = 1'b0;
    end

    // 8 MHz internal RC
    always #62.5 rc_osc_in = osc_enable.rc_enable & ~rc_osc_in;
    // 16 MHz external source; ext_run low models a dead crystal
    always #31.25 ext_clock_in = osc_enable.ext_enable & ext_run
        & ~ext_clock_in;
    // Kept slow enough to be seen by the 100 MHz sampler
    always #14 pll_clock_in = osc_enable.pll_enable & pll_run
        & ~pll_clock_in;
endmodule : osc_model

//--- test/tb_top.sv
// Bench for the clock control block: registers, sources, ticks, failure.
// Assumes osc_model drives the pins; clk_en is held high throughout.
`include "clock_control_cfg.svh"

module tb_top
    import clock_control_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic stop_mode = 1'b0;
    logic ext_run = 1'b1;
    logic pll_run = 1'b1;
    reg_req_type reg_req = '0;
    logic rc_osc_in;
    logic ext_clock_in;
    logic pll_clock_in;
    logic [31:0] reg_rdata;
    logic [31:0] rdata;
    clock_ticks_type ticks;
    osc_enable_type osc_enable;
    src_type active_source;
    logic irq;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int cnt [8];
    // Indexed by tick bit: adc, adv_timer, ..., core
    int rc_exp [8] = '{20, 80, 80, 40, 80, 20, 80, 160};
    logic [7:0] map [6] = '{`CC_CTRL_OFFSET, `CC_PRESC_OFFSET,
        `CC_STATUS_OFFSET, `CC_IRQ_STATUS_OFFSET, `CC_IRQ_MASK_OFFSET, 8'h14};

    always #5 sys_clk = ~sys_clk;

    clock_control clock_control_i (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
        .rc_osc_in(rc_osc_in), .ext_clock_in(ext_clock_in),
        .pll_clock_in(pll_clock_in), .stop_mode(stop_mode),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .ticks(ticks),
        .osc_enable(osc_enable), .active_source(active_source), .irq(irq));

    osc_model osc_model_i (
        .osc_enable(osc_enable), .ext_run(ext_run), .pll_run(pll_run),
        .rc_osc_in(rc_osc_in), .ext_clock_in(ext_clock_in),
        .pll_clock_in(pll_clock_in));

    task automatic complete_run();
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Pin edges are sampled asynchronously, so counts may slip by two
    task automatic check_cnt(input string name, input int exp, input int got);
        compares++;
        if (got < exp - 2 || got > exp + 2)
        begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_cnt

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1 rdata = reg_rdata;
    endtask : rd

    task automatic count_ticks(input int n);
        foreach (cnt[i])
            cnt[i] = 0;
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            foreach (cnt[i])
                if (ticks[i] === 1'b1)
                    cnt[i]++;
        end
    endtask : count_ticks

    task automatic wait_src(input src_type s);
        int k;
        k = 0;
        while (active_source !== s && k < 200)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        check("active_source", 32'(s), 32'(active_source));
    endtask : wait_src

    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 200)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        check("irq", 32'h0000_0001, {31'h0, irq});
    endtask : wait_irq

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            complete_run();
        end
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1 check("active_source", 32'(SRC_RC), 32'(active_source));
        foreach (map[i])
        begin
            rd(map[i]);
            check("reset value", 32'h0000_0000, rdata);
        end
        wr(`CC_PRESC_OFFSET, 32'h0000_5821);
        rd(`CC_PRESC_OFFSET);
        check("presc", 32'h0000_5821, rdata);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14);
        check("unmapped", 32'h0000_0000, rdata);
        count_ticks(2000);
        foreach (cnt[i])
            check_cnt("rc ticks", rc_exp[i], cnt[i]);
        wr(`CC_CTRL_OFFSET, 32'h0000_0030);
        count_ticks(2000);
        check_cnt("adc pll ticks", 119, cnt[0]);
        wr(`CC_CTRL_OFFSET, 32'h0000_0009);
        wait_src(SRC_EXT);
        rd(`CC_STATUS_OFFSET);
        check("status ext", 32'h0000_0001, rdata);
        count_ticks(2000);
        check_cnt("ext core ticks", 320, cnt[7]);
        wr(`CC_IRQ_MASK_OFFSET, 32'h0000_0001);
        @(posedge sys_clk);
        ext_run <= 1'b0;
        wait_irq();
        wait_src(SRC_RC);
        rd(`CC_STATUS_OFFSET);
        check("status failed", 32'h0000_0004, rdata);
        rd(`CC_IRQ_STATUS_OFFSET);
        check("irq status", 32'h0000_0001, rdata);
        check("irq cleared", 32'h0000_0000, {31'h0, irq});
        rd(`CC_IRQ_STATUS_OFFSET);
        check("irq status clr", 32'h0000_0000, rdata);
        ext_run <= 1'b1;
        wr(`CC_CTRL_OFFSET, 32'h0000_0089);
        wait_src(SRC_EXT);
        wr(`CC_IRQ_MASK_OFFSET, 32'h0000_0000);
        @(posedge sys_clk);
        ext_run <= 1'b0;
        wait_src(SRC_RC);
        check("masked irq", 32'h0000_0000, {31'h0, irq});
        rd(`CC_IRQ_STATUS_OFFSET);
        check("masked status", 32'h0000_0001, rdata);
        ext_run <= 1'b1;
        wr(`CC_IRQ_MASK_OFFSET, 32'h0000_0003);
        wr(`CC_CTRL_OFFSET, 32'h0000_00DE);
        wait_src(SRC_PLL);
        rd(`CC_STATUS_OFFSET);
        check("x2 allowed", 32'h0000_000A, rdata);
        count_ticks(700);
        check_cnt("x2 ticks", 500, cnt[1]);
        wr(`CC_PRESC_OFFSET, 32'h0000_58A1);
        rd(`CC_STATUS_OFFSET);
        check("x2 refused", 32'h0000_0002, rdata);
        @(posedge sys_clk);
        ext_run <= 1'b0;
        pll_run <= 1'b0;
        wait_irq();
        rd(`CC_IRQ_STATUS_OFFSET);
        check("pll input fail", 32'h0000_0002, rdata);
        stop_mode <= 1'b1;
        repeat (2) @(posedge sys_clk);
        count_ticks(50);
        check_cnt("stop ticks", 0, cnt.sum());
        check("stop osc", 32'h0000_0000, {29'h0, osc_enable});
        stop_mode <= 1'b0;
        complete_run();
    end
endmodule : tb_top
